// File: inc/timer_regs.svh
// Constants for the three-channel reload timer: widths, reset values, codes, bit positions.
// Included by the package, the prescaler and the timer unit; definitions only.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define TMR_CH_NUM        3
`define TMR_CNT_W         32
`define TMR_CNT_RST       32'hFFFFFFFF
`define TMR_CNT_ZERO      32'h00000000
`define TMR_CAP_RST       32'h00000000
`define TMR_PRE_W         8
`define TMR_PRE_RST       8'h00
`define TMR_DIV4_MASK     8'h03
`define TMR_DIV16_MASK    8'h0F
`define TMR_DIV64_MASK    8'h3F
`define TMR_DIV256_MASK   8'hFF
`define TMR_TICK_DIV4     0
`define TMR_TICK_DIV16    1
`define TMR_TICK_DIV64    2
`define TMR_TICK_DIV256   3
`define TMR_CAP_CH        2
`define TMR_EDGE_FALL_BIT 0
`define TMR_EDGE_BOTH_BIT 1
`define TMR_CAPM_INT_BIT  0
`define TMR_CAPM_EN_BIT   1
`define TMR_FLAG_CAP      3
`define TMR_RD_COUNT0     3'h0
`define TMR_RD_COUNT1     3'h1
`define TMR_RD_COUNT2     3'h2
`define TMR_RD_RELOAD0    3'h3
`define TMR_RD_RELOAD1    3'h4
`define TMR_RD_RELOAD2    3'h5
`define TMR_RD_CAPTURE    3'h6
`define TMR_IRQ_UNF0      2'h0
`define TMR_IRQ_UNF1      2'h1
`define TMR_IRQ_UNF2      2'h2
`define TMR_IRQ_CAP       2'h3

`endif

// File: inc/timer_pkg.sv
// Types shared by the timer unit modules.
// Assumes timer_regs.svh is on the include path.
`default_nettype none
`include "timer_regs.svh"

package timer_pkg;

    typedef enum logic [2:0] {
        CKSEL_DIV4   = 3'b000,
        CKSEL_DIV16  = 3'b001,
        CKSEL_DIV64  = 3'b010,
        CKSEL_DIV256 = 3'b011,
        CKSEL_CAL    = 3'b100,
        CKSEL_EXT    = 3'b101
    } clk_sel_type;

    typedef struct packed {
        logic [`TMR_PRE_W-1:0] div;
        logic [3:0]            tick;
    } prescale_state_type;

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        logic rise;
        logic fall;
    } pin_state_type;

    typedef struct packed {
        logic [`TMR_CH_NUM-1:0][`TMR_CNT_W-1:0] count;
        logic [`TMR_CH_NUM-1:0][`TMR_CNT_W-1:0] reload;
        logic [`TMR_CNT_W-1:0]                  capture;
        logic [`TMR_CH_NUM-1:0]                 unf;
        logic                                   cap_flag;
        logic [`TMR_CNT_W-1:0]                  rd_data;
        logic                                   rd_valid;
        logic                                   cal_last;
    } timer_state_type;

endpackage
`default_nettype wire

// File: rtl/timer_prescaler.sv
// Free-running divider of the peripheral clock giving one-cycle ticks at /4, /16, /64, /256.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "timer_regs.svh"

module timer_prescaler (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    output logic      [3:0] o_tick
);

    timer_pkg::prescale_state_type state;
    timer_pkg::prescale_state_type next_state;

    always_comb begin
        next_state      = state;
        next_state.div  = state.div + `TMR_PRE_W'(1);
        // Ticks nest: every /256 tick is also a /64, /16 and /4 tick
        next_state.tick[`TMR_TICK_DIV4]   = (state.div & `TMR_DIV4_MASK) == `TMR_DIV4_MASK;
        next_state.tick[`TMR_TICK_DIV16]  = (state.div & `TMR_DIV16_MASK) == `TMR_DIV16_MASK;
        next_state.tick[`TMR_TICK_DIV64]  = (state.div & `TMR_DIV64_MASK) == `TMR_DIV64_MASK;
        next_state.tick[`TMR_TICK_DIV256] = (state.div & `TMR_DIV256_MASK) == `TMR_DIV256_MASK;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_tick = state.tick;

endmodule // timer_prescaler
`default_nettype wire

// File: rtl/timer_pin_sync.sv
// Two-stage synchroniser and edge detector for the timer pin.
// Assumes the pin may change at any time relative to the clock.
`timescale 1ns/10ps
`default_nettype none

module timer_pin_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_pin,
    output logic      o_rise,
    output logic      o_fall
);

    timer_pkg::pin_state_type state;
    timer_pkg::pin_state_type next_state;

    always_comb begin
        next_state      = state;
        next_state.meta = i_pin;
        next_state.sync = state.meta;
        next_state.last = state.sync;
        // Edges only from the second stage on; meta feeds nothing else
        next_state.rise = state.sync & ~state.last;
        next_state.fall = ~state.sync & state.last;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_rise = state.rise;
    assign o_fall = state.fall;

endmodule // timer_pin_sync
`default_nettype wire

// File: rtl/timer_unit.sv
// Three-channel 32-bit down-counting timer with auto-reload, clock selection
// and input capture on channel 2. Control and status travel as plain ports.
// Assumes all inputs are synchronous to I_SYS_CLK except I_TIMER_PIN.
//
// Behaviour
// - Three channels, each a 32-bit down-counter and a 32-bit reload constant.
// - A channel counts only while its own run bit is set.
// - Counter underflow sets that channel's underflow flag.
// - On underflow the reload constant loads at once and counting continues.
// - A request goes out while a source's flag and its enable are set; capture needs both mode bits.
// - Clock select can pick the peripheral clock divided by 4, 16, 64 or 256.
// - Select codes 000-011 dividers, 100 calendar tick, 101 pin; 110, 111 reserved.
// - Pin clocking counts on rising, falling or both edges per edge select.
// - Clock select can pick the calendar tick as count clock.
// - Only channel 2 captures its counter on a timer pin edge: falling if its fall select bit is set, else rising.
// - Two capture mode bits enable capture and its interrupt.
// - Capture is inert during standby.
// - Sources: underflow 0, 1, 2 then capture, highest to lowest priority.
// - Writing 0 clears an underflow or capture flag; writing 1 leaves it.
// - A read colliding with a decrement returns the value before it.
`timescale 1ns/10ps
`default_nettype none
`include "timer_regs.svh"

module timer_unit (
    input  wire logic                                   I_SYS_CLK,
    input  wire logic                                   I_RST,
    input  wire logic [`TMR_CH_NUM-1:0]                 I_RUN,
    input  wire logic [`TMR_CH_NUM-1:0][2:0]            I_CLK_SEL,
    input  wire logic [`TMR_CH_NUM-1:0][1:0]            I_EDGE_SEL,
    input  wire logic [`TMR_CH_NUM-1:0]                 I_UNF_IRQ_EN,
    input  wire logic [1:0]                             I_CAP_MODE,
    input  wire logic                                   I_PIN_DIR_OUT,
    input  wire logic                                   I_STANDBY,
    input  wire logic                                   I_CAL_TICK,
    input  wire logic                                   I_TIMER_PIN_I,
    input  wire logic [1:0]                             I_WR_CH,
    input  wire logic                                   I_WR_COUNT,
    input  wire logic                                   I_WR_RELOAD,
    input  wire logic [`TMR_CNT_W-1:0]                  I_WR_DATA,
    input  wire logic                                   I_FLAG_WR,
    input  wire logic [3:0]                             I_FLAG_WR_DATA,
    input  wire logic                                   I_RD,
    input  wire logic [2:0]                             I_RD_SEL,
    output logic      [`TMR_CNT_W-1:0]                  O_RD_DATA,
    output logic                                        O_RD_VALID,
    output logic      [`TMR_CH_NUM-1:0]                 O_UNF_FLAG,
    output logic                                        O_CAP_FLAG,
    output logic      [`TMR_CH_NUM-1:0]                 O_UNF_IRQ,
    output logic                                        O_CAP_IRQ,
    output logic                                        O_IRQ_ANY,
    output logic      [1:0]                             O_IRQ_SRC,
    output logic      [`TMR_CNT_W-1:0]                  O_CAPTURE,
    output logic                                        O_TIMER_PIN_O,
    output logic                                        O_TIMER_PIN_OE
);

    timer_pkg::timer_state_type state;
    timer_pkg::timer_state_type next_state;

    logic [3:0]             pre_tick;
    logic                   pin_rise;
    logic                   pin_fall;
    logic                   cal_rise;
    logic [`TMR_CH_NUM-1:0] step;
    logic                   cap_event;

    timer_prescaler u_prescaler (
        .i_clk  (I_SYS_CLK),
        .i_rst  (I_RST),
        .o_tick (pre_tick)
    );

    // Pin is sampled even while driven out, so its edges stay defined
    timer_pin_sync u_pin_sync (
        .i_clk  (I_SYS_CLK),
        .i_rst  (I_RST),
        .i_pin  (I_TIMER_PIN_I),
        .o_rise (pin_rise),
        .o_fall (pin_fall)
    );

    // Calendar tick is a level; count once per rising edge of it
    assign cal_rise = I_CAL_TICK & ~state.cal_last;

    genvar ch;
    generate
        for (ch = 0; ch < `TMR_CH_NUM; ch = ch + 1) begin : g_tick
            logic ext_edge;
            logic tick;

            always_comb begin
                if (I_EDGE_SEL[ch][`TMR_EDGE_BOTH_BIT]) begin
                    ext_edge = pin_rise | pin_fall;
                end else if (I_EDGE_SEL[ch][`TMR_EDGE_FALL_BIT]) begin
                    ext_edge = pin_fall;
                end else begin
                    ext_edge = pin_rise;
                end
            end

            always_comb begin
                unique case (timer_pkg::clk_sel_type'(I_CLK_SEL[ch]))
                    timer_pkg::CKSEL_DIV4:   tick = pre_tick[`TMR_TICK_DIV4];
                    timer_pkg::CKSEL_DIV16:  tick = pre_tick[`TMR_TICK_DIV16];
                    timer_pkg::CKSEL_DIV64:  tick = pre_tick[`TMR_TICK_DIV64];
                    timer_pkg::CKSEL_DIV256: tick = pre_tick[`TMR_TICK_DIV256];
                    timer_pkg::CKSEL_CAL:    tick = cal_rise;
                    timer_pkg::CKSEL_EXT:    tick = ext_edge;
                    // Reserved codes never count
                    default:                 tick = 1'b0;
                endcase
            end

            assign step[ch] = I_RUN[ch] & tick;
        end
    endgenerate

    // Capture uses only the rise/fall choice; the both-edge bit is ignored here
    always_comb begin
        cap_event = 1'b0;
        if (I_CAP_MODE[`TMR_CAPM_EN_BIT] && !I_STANDBY && !I_PIN_DIR_OUT) begin
            if (I_EDGE_SEL[`TMR_CAP_CH][`TMR_EDGE_FALL_BIT]) begin
                cap_event = pin_fall;
            end else begin
                cap_event = pin_rise;
            end
        end
    end

    always_comb begin
        next_state          = state;
        next_state.cal_last = I_CAL_TICK;
        next_state.rd_valid = I_RD;

        // Read samples present state, so a read meeting a decrement sees the old value
        if (I_RD) begin
            unique case (I_RD_SEL)
                `TMR_RD_COUNT0:  next_state.rd_data = state.count[0];
                `TMR_RD_COUNT1:  next_state.rd_data = state.count[1];
                `TMR_RD_COUNT2:  next_state.rd_data = state.count[2];
                `TMR_RD_RELOAD0: next_state.rd_data = state.reload[0];
                `TMR_RD_RELOAD1: next_state.rd_data = state.reload[1];
                `TMR_RD_RELOAD2: next_state.rd_data = state.reload[2];
                `TMR_RD_CAPTURE: next_state.rd_data = state.capture;
                default:         next_state.rd_data = `TMR_CNT_ZERO;
            endcase
        end

        for (int i = 0; i < `TMR_CH_NUM; i++) begin
            // Flag clear first, so an underflow in the same cycle wins
            if (I_FLAG_WR && !I_FLAG_WR_DATA[i]) begin
                next_state.unf[i] = 1'b0;
            end
            if (step[i]) begin
                if (state.count[i] == `TMR_CNT_ZERO) begin
                    next_state.count[i] = state.reload[i];
                    next_state.unf[i]   = 1'b1;
                end else begin
                    next_state.count[i] = state.count[i] - `TMR_CNT_W'(1);
                end
            end
            // Writes are not held off by counting; software stops the channel first
            if (I_WR_COUNT && (I_WR_CH == 2'(i))) begin
                next_state.count[i] = I_WR_DATA;
            end
            if (I_WR_RELOAD && (I_WR_CH == 2'(i))) begin
                next_state.reload[i] = I_WR_DATA;
            end
        end

        if (I_FLAG_WR && !I_FLAG_WR_DATA[`TMR_FLAG_CAP]) begin
            next_state.cap_flag = 1'b0;
        end
        if (cap_event) begin
            next_state.capture  = state.count[`TMR_CAP_CH];
            next_state.cap_flag = 1'b1;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            state          <= '0;
            state.count    <= {`TMR_CH_NUM{`TMR_CNT_RST}};
            state.reload   <= {`TMR_CH_NUM{`TMR_CNT_RST}};
            state.capture  <= `TMR_CAP_RST;
        end else begin
            state <= next_state;
        end
    end

    assign O_UNF_IRQ = state.unf & I_UNF_IRQ_EN;
    assign O_CAP_IRQ = state.cap_flag & I_CAP_MODE[`TMR_CAPM_EN_BIT]
                       & I_CAP_MODE[`TMR_CAPM_INT_BIT];
    assign O_IRQ_ANY = (|O_UNF_IRQ) | O_CAP_IRQ;

    // Fixed priority; an outside controller may reorder channels
    always_comb begin
        if (O_UNF_IRQ[0]) begin
            O_IRQ_SRC = `TMR_IRQ_UNF0;
        end else if (O_UNF_IRQ[1]) begin
            O_IRQ_SRC = `TMR_IRQ_UNF1;
        end else if (O_UNF_IRQ[2]) begin
            O_IRQ_SRC = `TMR_IRQ_UNF2;
        end else begin
            O_IRQ_SRC = `TMR_IRQ_CAP;
        end
    end

    assign O_RD_DATA      = state.rd_data;
    assign O_RD_VALID     = state.rd_valid;
    assign O_UNF_FLAG     = state.unf;
    assign O_CAP_FLAG     = state.cap_flag;
    assign O_CAPTURE      = state.capture;
    // Pin doubles as calendar clock output when turned round
    assign O_TIMER_PIN_O  = I_CAL_TICK;
    assign O_TIMER_PIN_OE = I_PIN_DIR_OUT;

endmodule // timer_unit
`default_nettype wire

// File: verif/timer_unit_properties.sv
// Port-level checks of the timer unit, bound into timer_unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module timer_unit_properties (
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST,
    input wire logic [2:0]  I_RUN,
    input wire logic [2:0]  I_UNF_IRQ_EN,
    input wire logic [1:0]  I_CAP_MODE,
    input wire logic        I_PIN_DIR_OUT,
    input wire logic        I_STANDBY,
    input wire logic        I_FLAG_WR,
    input wire logic [3:0]  I_FLAG_WR_DATA,
    input wire logic        I_RD,
    input wire logic        O_RD_VALID,
    input wire logic [2:0]  O_UNF_FLAG,
    input wire logic        O_CAP_FLAG,
    input wire logic [2:0]  O_UNF_IRQ,
    input wire logic        O_CAP_IRQ,
    input wire logic        O_IRQ_ANY,
    input wire logic [1:0]  O_IRQ_SRC,
    input wire logic [31:0] O_CAPTURE
);
    logic [2:0] keep;
    assign keep = O_UNF_FLAG & ~({3{I_FLAG_WR}} & ~I_FLAG_WR_DATA[2:0]);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    chk_unf_irq_gate: assert property (O_UNF_IRQ == (O_UNF_FLAG & I_UNF_IRQ_EN))
        else $error("underflow request mismatch");
    chk_cap_irq_gate: assert property (O_CAP_IRQ == (O_CAP_FLAG & (&I_CAP_MODE)))
        else $error("capture request mismatch");
    chk_irq_order: assert property (O_IRQ_ANY == ((|O_UNF_IRQ) | O_CAP_IRQ)
        && (!O_IRQ_ANY || O_IRQ_SRC == (O_UNF_IRQ[0] ? 2'h0 : O_UNF_IRQ[1] ? 2'h1
        : O_UNF_IRQ[2] ? 2'h2 : 2'h3))) else $error("request priority wrong");
    chk_unf_sticky: assert property (1'b1 |=> (O_UNF_FLAG & $past(keep)) == $past(keep))
        else $error("underflow flag lost");
    chk_cap_sticky: assert property (O_CAP_FLAG && !(I_FLAG_WR && !I_FLAG_WR_DATA[3])
        |=> O_CAP_FLAG) else $error("capture flag lost");
    chk_unf_needs_run: assert property ((O_UNF_FLAG & ~$past(O_UNF_FLAG) & ~$past(I_RUN))
        == 3'h0) else $error("underflow on stopped channel");
    chk_cap_standby: assert property (I_STANDBY |=> $stable(O_CAPTURE))
        else $error("capture in standby");
    chk_cap_blocked: assert property ((I_PIN_DIR_OUT || !I_CAP_MODE[1])
        |=> $stable(O_CAPTURE) && !$rose(O_CAP_FLAG)) else $error("capture while disabled");
    chk_cap_flag_set: assert property ($changed(O_CAPTURE) |-> O_CAP_FLAG)
        else $error("capture without flag");
    chk_read_pulse: assert property (1'b1 |=> O_RD_VALID == $past(I_RD))
        else $error("read answer timing wrong");
endmodule // timer_unit_properties

bind timer_unit timer_unit_properties u_props (.I_SYS_CLK, .I_RST, .I_RUN, .I_UNF_IRQ_EN,
    .I_CAP_MODE, .I_PIN_DIR_OUT, .I_STANDBY, .I_FLAG_WR, .I_FLAG_WR_DATA, .I_RD, .O_RD_VALID,
    .O_UNF_FLAG, .O_CAP_FLAG, .O_UNF_IRQ, .O_CAP_IRQ, .O_IRQ_ANY, .O_IRQ_SRC, .O_CAPTURE);
`default_nettype wire

// File: verif/ext_pulse_src.sv
// Pulse source standing on the timer pin.
// Driven off the falling clock edge; idles low when disabled.
`timescale 1ns/10ps
`default_nettype none
module ext_pulse_src (
    input  wire logic       i_clk,
    input  wire logic       i_en,
    input  wire logic [7:0] i_half,
    output logic            o_pin
);
    logic [7:0] cnt;
    initial begin
        o_pin = 1'b0;
        cnt   = 8'h00;
    end
    // Each level held i_half cycles; 3 or more meets both widths
    always @(negedge i_clk) begin
        if (!i_en) begin
            o_pin <= 1'b0;
            cnt   <= 8'h00;
        end else if (cnt == i_half - 8'h01) begin
            o_pin <= ~o_pin;
            cnt   <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // ext_pulse_src
`default_nettype wire

// File: verif/timer_unit_tb_top.sv
// Self-checking bench for the timer unit.
// Inputs change on the falling edge; expectations from the port contract.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module timer_unit_tb_top;
    logic            clk, rst, stby, cal, pin, dir, wr_cnt, wr_rel, fwr, rd, src_en;
    logic            rd_valid, cap_flag, cap_irq, irq_any, pin_o, pin_oe;
    logic [2:0]      run, irq_en, rd_sel, unf_flag, unf_irq;
    logic [2:0][2:0] csel;
    logic [2:0][1:0] esel;
    logic [1:0]      cap_mode, wr_ch, irq_src;
    logic [31:0]     wr_data, rd_data, capture;
    logic [3:0]      fdata;
    logic [7:0]      half;
    int              n_mismatch = 0;
    int              num_checks = 0;
    int              n;

    timer_unit dut (.I_SYS_CLK(clk), .I_RST(rst), .I_RUN(run), .I_CLK_SEL(csel),
        .I_EDGE_SEL(esel), .I_UNF_IRQ_EN(irq_en), .I_CAP_MODE(cap_mode), .I_PIN_DIR_OUT(dir),
        .I_STANDBY(stby), .I_CAL_TICK(cal), .I_TIMER_PIN_I(pin), .I_WR_CH(wr_ch),
        .I_WR_COUNT(wr_cnt), .I_WR_RELOAD(wr_rel), .I_WR_DATA(wr_data), .I_FLAG_WR(fwr),
        .I_FLAG_WR_DATA(fdata), .I_RD(rd), .I_RD_SEL(rd_sel), .O_RD_DATA(rd_data),
        .O_RD_VALID(rd_valid), .O_UNF_FLAG(unf_flag), .O_CAP_FLAG(cap_flag),
        .O_UNF_IRQ(unf_irq), .O_CAP_IRQ(cap_irq), .O_IRQ_ANY(irq_any), .O_IRQ_SRC(irq_src),
        .O_CAPTURE(capture), .O_TIMER_PIN_O(pin_o), .O_TIMER_PIN_OE(pin_oe));
    ext_pulse_src u_src (.i_clk(clk), .i_en(src_en), .i_half(half), .o_pin(pin));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Calendar tick: rising edge every 20 cycles
    initial begin
        cal = 1'b0;
        forever begin
            repeat (10) @(negedge clk);
            cal = ~cal;
        end
    end

    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [1:0] ch, input logic rel, input logic [31:0] d);
        @(negedge clk);
        wr_ch = ch;
        wr_cnt = !rel;
        wr_rel = rel;
        wr_data = d;
        @(negedge clk);
        wr_cnt = 1'b0;
        wr_rel = 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] s, input logic [31:0] e);
        @(negedge clk);
        rd = 1'b1;
        rd_sel = s;
        @(negedge clk);
        rd = 1'b0;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, e)
    endtask
    task automatic flag_wr(input logic [3:0] d);
        @(negedge clk);
        fwr = 1'b1;
        fdata = d;
        @(negedge clk);
        fwr = 1'b0;
    endtask
    task automatic wait_flag(input int lim);
        n = 0;
        do begin
            @(negedge clk);
            fwr = 1'b0;
            n++;
        end while (unf_flag[1] !== 1'b1 && n < lim);
    endtask
    // Reload 0: every count step underflows, so flag spacing is the step period
    task automatic period(input logic [2:0] cs, input logic [1:0] es, input int lim);
        run[1] = 1'b0;
        wr(2'h1, 1'b1, 32'h0);
        wr(2'h1, 1'b0, 32'h0);
        flag_wr(4'hD);
        csel[1] = cs;
        esel[1] = es;
        run[1] = 1'b1;
        wait_flag(lim);
        fwr = 1'b1;
        fdata = 4'hD;
        wait_flag(lim);
    endtask
    task automatic burst();
        src_en = 1'b1;
        repeat (30) @(negedge clk);
        src_en = 1'b0;
        repeat (8) @(negedge clk);
    endtask

    initial begin
        {rst, stby, dir, wr_cnt, wr_rel, fwr, rd, src_en} = 8'h80;
        {run, irq_en, rd_sel, csel, esel} = 24'h0;
        {cap_mode, wr_ch, wr_data, fdata} = 40'h0;
        half = 8'h04;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        for (int s = 0; s < 6; s++) rd_chk(s[2:0], 32'hFFFFFFFF);
        rd_chk(3'h6, 32'h0);
        wr(2'h0, 1'b0, 32'h5);
        repeat (40) @(negedge clk);
        rd_chk(3'h0, 32'h5);
        irq_en = 3'h1;
        wr(2'h0, 1'b1, 32'h7);
        run[0] = 1'b1;
        n = 0;
        while (unf_flag[0] !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        run[0] = 1'b0;
        `CHK(unf_irq, 3'h1)
        `CHK(irq_src, 2'h0)
        rd_chk(3'h0, 32'h7);
        flag_wr(4'hF);
        `CHK(unf_flag[0], 1'b1)
        flag_wr(4'hE);
        `CHK(unf_flag[0], 1'b0)
        `CHK(irq_any, 1'b0)
        for (int i = 0; i < 4; i++) begin
            period(i[2:0], 2'h0, 1000);
            `CHK(n, 4 << (2 * i))
        end
        period(3'h4, 2'h0, 1000);
        `CHK(n, 20)
        src_en = 1'b1;
        for (int e = 0; e < 3; e++) begin
            period(3'h5, e[1:0], 1000);
            `CHK(n, (e == 2) ? 4 : 8)
        end
        for (int r = 6; r < 8; r++) begin
            period(r[2:0], 2'h0, 300);
            `CHK(unf_flag[1], 1'b0)
            `CHK(n, 300)
        end
        src_en = 1'b0;
        run = 3'h0;
        flag_wr(4'h8);
        wr(2'h2, 1'b0, 32'h1234ABCD);
        // Pin left as input, channel 2 on the internal /4 clock
        `CHK(pin_oe, 1'b0)
        cap_mode = 2'h3;
        burst();
        `CHK(capture, 32'h1234ABCD)
        `CHK(cap_irq, 1'b1)
        `CHK(irq_src, 2'h3)
        `CHK(irq_any, 1'b1)
        wr(2'h2, 1'b0, 32'h55);
        stby = 1'b1;
        burst();
        `CHK(capture, 32'h1234ABCD)
        stby = 1'b0;
        dir = 1'b1;
        burst();
        `CHK(capture, 32'h1234ABCD)
        `CHK(pin_oe, 1'b1)
        `CHK(pin_o, cal)
        dir = 1'b0;
        cap_mode = 2'h2;
        esel[2] = 2'h1;
        flag_wr(4'h7);
        `CHK(cap_flag, 1'b0)
        burst();
        `CHK(capture, 32'h55)
        `CHK({cap_flag, cap_irq}, 2'h2)
        results();
    end
    // Whole run is a few thousand cycles; this bound only cuts a hang
    initial begin
        #(4 * 20000);
        n_mismatch++;
        results();
    end
endmodule // timer_unit_tb_top
`default_nettype wire
